// ---- src/mwp_top.sv ----
// Purpose: memory window paging unit top level
// Assumes: cpu address and strobe synchronous to pclk
// Notes:   window hit is combinational; port outputs are registered per cycle
//          pins 13..15 follow the cpu when assigned but not banked
//          a 4000-based 32k window claims line 14 for the inverted address
//          the vector-fetch input always bypasses the on-chip rom
//
// How it works
// - on-chip regs/ram/eeprom repeat in all banks
// - rom answers only in banks with top bits zero
// - no window enabled: vector from FFFE
// - expansion on: vector fetched at 7FFE
// - pin bits choose gpio or expansion line
// - unused upper expansion bit (lines 3..5) frees its pin
// - assigned unused low lines carry cpu bit
// - size code: off, 8k, 16k, 32k
// - base register layout, reserved zero, reset zero
// - base decoding depends on window size
// - windows aligned to their own size, except a 32k window at 4000
// - bank register drives expansion lines on hit, except line 14 while a 32k window sits at 4000
// - bank bit drives only assigned pins
// - window 1 wins any overlap
// - 4000-based 32k window inverts address 14
// - used low lines replace cpu address bits, line 14 only while no 32k window sits at 4000
//
// Our own choice: the APB slave port.
`timescale 1ns/10ps
module mwp_top
  import mwp_pkg::*;
(
  input  wire logic        pclk,          // bus clock
  input  wire logic        presetn,       // async reset, active low
  input  wire logic        psel,          // apb select
  input  wire logic        penable,       // apb access phase
  input  wire logic        pwrite,        // apb direction
  input  wire logic [11:0] paddr,         // apb byte address
  input  wire logic [31:0] pwdata,        // apb write data
  output logic [31:0]      prdata,        // apb read data
  output logic             pready,        // apb ready
  output logic             pslverr,       // apb error
  input  wire logic [15:0] cpu_addr,      // cpu address bus
  input  wire logic        cpu_vec_fetch, // cpu is fetching reset vector
  input  wire logic        onchip_hit,    // address hits regs, ram or eeprom
  input  wire logic        rom_hit,       // address hits on-chip program rom
  input  wire logic [5:0]  gpio_out,      // gpio output values for port pins
  input  wire logic [5:0]  gpio_dir,      // gpio drive enables, 1 drives
  output logic [5:0]       pin_out,       // port pin output value
  output logic [5:0]       pin_oe_n,      // port pin enable, low drives
  output logic [15:13]     bus_addr_hi,   // external address bits 15..13
  output logic [15:0]      vec_addr,      // reset vector fetch address
  output logic             ext_select,    // access goes to external memory
  output logic             rom_select,    // access goes to on-chip rom
  output logic [1:0]       win_active     // window 2/1 hit in the previous cycle
);

  // register copies from the apb block
  logic [7:0] size_q;       // window_size_select
  logic [7:0] base_q;       // window_base_select
  logic [7:0] bank1_q;      // window1_bank_number
  logic [7:0] bank2_q;      // window2_bank_number
  logic [7:0] pin_q;        // expansion_pin_assign
  logic [7:0] cfg_q;        // rom configuration
  // window decode results
  logic       hit1;         // window 1 hit
  logic       hit2_raw;     // window 2 hit before priority
  logic       hit2;         // window 2 hit after priority
  logic       w1_4000;      // window 1 is 32k at 4000
  logic       w2_4000;      // window 2 is 32k at 4000
  logic       w1_inv14;     // window 1 sized 32k and based at 4000
  logic       w2_inv14;     // window 2 sized 32k and based at 4000
  logic       line14_inv;   // line 14 carries inverted address
  // bank and line selection
  logic [5:0] bank_sel;     // selected bank number
  logic [5:0] used_mask;    // expansion lines used by any window
  logic [5:0] xa_val;       // expansion_address_lines value
  // pin and routing
  logic [5:0] drive_d;      // pin drive values
  logic [5:0] oe_n_d;       // pin enables
  logic       any_hit;      // some window hit
  logic       rom_ok;       // rom allowed in current bank
  logic       rom_take;     // rom answers this access
  logic       exp_en;       // expanded memory enabled

  // register file behind apb
  mwp_apb_regs u_regs
  (
    .pclk    (pclk),
    .presetn (presetn),
    .psel    (psel),
    .penable (penable),
    .pwrite  (pwrite),
    .paddr   (paddr),
    .pwdata  (pwdata),
    .prdata  (prdata),
    .pslverr (pslverr),
    .size_q  (size_q),
    .base_q  (base_q),
    .bank1_q (bank1_q),
    .bank2_q (bank2_q),
    .pin_q   (pin_q),
    .cfg_q   (cfg_q)
  );

  // window 1 decode
  mwp_win_decode u_win1
  (
    .size_code (size_q[SZ1_LSB +: 2]),
    .base_bits (base_q[BA1_LSB +: 3]),
    .cpu_addr  (cpu_addr),
    .hit       (hit1),
    .at_4000   (w1_4000)
  );

  // window 2 decode
  mwp_win_decode u_win2
  (
    .size_code (size_q[SZ2_LSB +: 2]),
    .base_bits (base_q[BA2_LSB +: 3]),
    .cpu_addr  (cpu_addr),
    .hit       (hit2_raw),
    .at_4000   (w2_4000)
  );

  // used line mask for a window size
  function automatic logic [5:0] used_lines(input logic [1:0] sz);
    case (sz)
      WSZ_8K:  used_lines = 6'b111111;
      WSZ_16K: used_lines = 6'b111110;
      WSZ_32K: used_lines = 6'b111100;
      default: used_lines = 6'b000000;
    endcase
  endfunction : used_lines

  // 32k window based at 4000 needs line 14 handling
  function automatic logic is_4000_32k(input logic [1:0] sz, input logic at);
    is_4000_32k = (sz == WSZ_32K) && at;
  endfunction : is_4000_32k

  // line 14 special case per window
  always_comb
  begin
    w1_inv14   = is_4000_32k(size_q[SZ1_LSB +: 2], w1_4000);
    w2_inv14   = is_4000_32k(size_q[SZ2_LSB +: 2], w2_4000);
    line14_inv = (hit1 && w1_inv14) || (hit2 && w2_inv14);
  end

  // apb answers with no wait states
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pready <= 1'b0;
    // one-cycle answer in the first access cycle
    else
      pready <= psel && !penable;
  end

  // hit priority and bank selection
  always_comb
  begin
    // window 1 wins any overlap
    hit2     = hit2_raw && !hit1;
    any_hit  = hit1 || hit2;
    // bank number of whichever window hit
    bank_sel = hit1 ? bank1_q[BANK_LSB +: 6] : bank2_q[BANK_LSB +: 6];
    // any enabled window means expanded memory
    exp_en   = (size_q[SZ1_LSB +: 2] != WSZ_OFF) || (size_q[SZ2_LSB +: 2] != WSZ_OFF);
    // lines claimed by either window size
    used_mask = used_lines(size_q[SZ1_LSB +: 2]) | used_lines(size_q[SZ2_LSB +: 2]);
    // a 4000-based window also claims line 14
    if (w1_inv14 || w2_inv14)
      used_mask[1] = 1'b1;
    // rom shows only in banks whose top three bits are zero
    rom_ok   = !any_hit || (bank_sel[5:3] == 3'b000);
  end

  // rom may answer: present, bank allowed, not a vector fetch
  always_comb
  begin
    rom_take = rom_hit && cfg_q[CFG_ROM_EN] && rom_ok && !cpu_vec_fetch;
  end

  // expansion line values
  always_comb
  begin
    xa_val = 6'b000000;
    for (int i = 0; i < 6; i++)
    begin
      // banked line inside a hit window
      if (any_hit && used_mask[i])
        xa_val[i] = bank_sel[i];
      // low lines fall back to the cpu address
      else if (i < 3)
        xa_val[i] = cpu_addr[13 + i];
      // upper lines idle low when not banked
      else
        xa_val[i] = 1'b0;
    end
    // 4000-based 32k window: line 14 carries inverted address 14
    if (line14_inv)
      xa_val[1] = !cpu_addr[14];
    else if (!(any_hit && used_mask[1] && !(w1_4000 || w2_4000)))
      xa_val[1] = cpu_addr[14];
  end

  // pin function per line
  generate
    for (genvar g = 0; g < 6; g++)
    begin : g_pin
      always_comb
      begin
        if (pin_q[g] && (used_mask[g] || g < 3))
        begin
          // assigned and in use, or an assigned low line: drive the expansion line
          drive_d[g] = xa_val[g];
          oe_n_d[g]  = 1'b0;
        end
        else
        begin
          // free pin: plain gpio
          drive_d[g] = gpio_out[g];
          oe_n_d[g]  = !gpio_dir[g];
        end
      end
    end
  endgenerate

  // registered pin outputs
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      // all pins released during reset
      pin_out  <= 6'b000000;
      pin_oe_n <= 6'b111111;
    end
    else
    begin
      pin_out  <= drive_d;
      pin_oe_n <= oe_n_d;
    end
  end

  // replaced cpu high address bits
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      bus_addr_hi <= 3'b000;
    // low lines as seen on the external bus
    else
      bus_addr_hi <= xa_val[2:0];
  end

  // external or on-chip routing
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ext_select <= 1'b0;
      rom_select <= 1'b0;
    end
    else
    begin
      // on-chip regs, ram and eeprom show through every bank
      if (onchip_hit)
      begin
        ext_select <= 1'b0;
        rom_select <= 1'b0;
      end
      else if (rom_take)
      begin
        ext_select <= 1'b0;
        rom_select <= 1'b1;
      end
      // everything else goes out to paged memory
      else
      begin
        ext_select <= 1'b1;
        rom_select <= 1'b0;
      end
    end
  end

  // window activity after priority
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      win_active <= 2'b00;
    else
      win_active <= {hit2, hit1};
  end

  // reset vector placement
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      vec_addr <= VEC_HIGH;
    // expanded memory: vector from the external 7FFE pair
    else if (exp_en)
      vec_addr <= VEC_EXP;
    else
      vec_addr <= VEC_HIGH;
  end

endmodule : mwp_top

// ---- src/mwp_pkg.sv ----
// Purpose: shared constants for the memory window paging unit
// Assumes: APB with 32-bit data, one aligned word per register
// Notes:   printed offsets are not multiples of four, so byte address = 4 * index
package mwp_pkg;

  // register indices as printed
  localparam logic [7:0]  SIZE_IDX      = 8'h56;  // window_size_select
  localparam logic [7:0]  BASE_IDX      = 8'h57;  // window_base_select
  localparam logic [7:0]  BANK1_IDX     = 8'h58;  // window1_bank_number
  localparam logic [7:0]  BANK2_IDX     = 8'h59;  // window2_bank_number
  localparam logic [7:0]  PIN_IDX       = 8'h5A;  // expansion_pin_assign
  localparam logic [7:0]  CFG_IDX       = 8'h5B;  // on-chip resource configuration

  // register reset values
  localparam logic [7:0]  SIZE_RST      = 8'h00;
  localparam logic [7:0]  BASE_RST      = 8'h00;
  localparam logic [7:0]  BANK_RST      = 8'h00;
  localparam logic [7:0]  PIN_RST       = 8'h00;
  localparam logic [7:0]  CFG_RST       = 8'h00;

  // writable bit masks
  localparam logic [7:0]  BASE_MASK     = 8'hEE;  // bits 4 and 0 read zero
  localparam logic [7:0]  BANK_MASK     = 8'h7E;  // bits 7 and 0 read zero
  localparam logic [7:0]  PIN_MASK      = 8'h3F;  // six pin assignment bits
  localparam logic [7:0]  CFG_MASK      = 8'h07;

  // field positions
  localparam int          SZ1_LSB       = 0;      // first_window_size
  localparam int          SZ2_LSB       = 4;      // second_window_size
  localparam int          BA1_LSB       = 1;      // first_window_base_bits
  localparam int          BA2_LSB       = 5;      // second_window_base_bits
  localparam int          BANK_LSB      = 1;      // bank bits 6..1
  localparam int          CFG_ROM_EN    = 0;      // on-chip program rom present
  localparam int          CFG_ROM_LOW   = 1;      // rom relocated to low range
  localparam int          CFG_OC_HIT    = 2;      // unused, reserved

  // window size codes
  localparam logic [1:0]  WSZ_OFF       = 2'b00;
  localparam logic [1:0]  WSZ_8K        = 2'b01;
  localparam logic [1:0]  WSZ_16K       = 2'b10;
  localparam logic [1:0]  WSZ_32K       = 2'b11;

  // fixed address figures
  localparam logic [15:0] VEC_HIGH      = 16'hFFFE;
  localparam logic [15:0] VEC_EXP       = 16'h7FFE;
  localparam logic [15:0] BASE_4000     = 16'h4000;

endpackage : mwp_pkg

// ---- src/mwp_win_decode.sv ----
// Purpose: decode one window's base, size and hit for a CPU address
// Assumes: cpu address is the current, settled address
// Notes:   purely combinational
`timescale 1ns/10ps
module mwp_win_decode
  import mwp_pkg::*;
(
  input  wire logic [1:0]  size_code,   // two-bit size field
  input  wire logic [2:0]  base_bits,   // three base bits
  input  wire logic [15:0] cpu_addr,    // current cpu address
  output logic             hit,         // address inside enabled window
  output logic             at_4000      // 32k window based at 4000
);

  // base and span by size
  always_comb
  begin
    hit     = 1'b0;
    at_4000 = 1'b0;
    case (size_code)
      WSZ_8K:  hit = (cpu_addr[15:13] == base_bits);
      WSZ_16K: hit = (cpu_addr[15:14] == base_bits[2:1]);
      WSZ_32K:
      begin
        if (base_bits[2])
          hit = cpu_addr[15];                                          // 8000
        else if (base_bits[1])
        begin
          at_4000 = 1'b1;
          hit     = (cpu_addr[15:14] == 2'b01) || (cpu_addr[15:14] == 2'b10); // 4000
        end
        else
          hit = !cpu_addr[15];                                         // 0000
      end
      default: hit = 1'b0;                                             // disabled
    endcase
  end

endmodule : mwp_win_decode

// ---- src/mwp_apb_regs.sv ----
// Purpose: apb slave holding the paging registers
// Assumes: zero-wait access, pready high in access phase
// Notes:   unmapped addresses read zero and answer pslverr
`timescale 1ns/10ps
module mwp_apb_regs
  import mwp_pkg::*;
(
  input  wire logic        pclk,       // bus clock
  input  wire logic        presetn,    // async reset, active low
  input  wire logic        psel,       // apb select
  input  wire logic        penable,    // apb access phase
  input  wire logic        pwrite,     // apb direction
  input  wire logic [11:0] paddr,      // apb byte address
  input  wire logic [31:0] pwdata,     // apb write data
  output logic [31:0]      prdata,     // apb read data
  output logic             pslverr,    // apb error
  output logic [7:0]       size_q,     // window_size_select
  output logic [7:0]       base_q,     // window_base_select
  output logic [7:0]       bank1_q,    // window1_bank_number
  output logic [7:0]       bank2_q,    // window2_bank_number
  output logic [7:0]       pin_q,      // expansion_pin_assign
  output logic [7:0]       cfg_q       // rom configuration
);

  logic [7:0] idx;     // register index
  logic       mapped;  // index decodes
  logic [7:0] rd;      // selected read value
  logic       wr;      // write takes effect

  assign idx = paddr[9:2];
  assign wr  = psel && penable && pwrite && mapped;

  // address decode and read mux
  always_comb
  begin
    mapped = 1'b1;
    if (idx == SIZE_IDX)       rd = size_q;
    else if (idx == BASE_IDX)  rd = base_q;
    else if (idx == BANK1_IDX) rd = bank1_q;
    else if (idx == BANK2_IDX) rd = bank2_q;
    else if (idx == PIN_IDX)   rd = pin_q;
    else if (idx == CFG_IDX)   rd = cfg_q;
    else
    begin
      rd     = 8'h00;
      mapped = 1'b0;                                                    // refused index
    end
  end

  // register writes, reserved bits masked except in the size register
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      size_q  <= SIZE_RST;
      base_q  <= BASE_RST;
      bank1_q <= BANK_RST;
      bank2_q <= BANK_RST;
      pin_q   <= PIN_RST;
      cfg_q   <= CFG_RST;
    end
    else if (wr)
    begin
      if (idx == SIZE_IDX)       size_q  <= pwdata[7:0];
      else if (idx == BASE_IDX)  base_q  <= pwdata[7:0] & BASE_MASK;
      else if (idx == BANK1_IDX) bank1_q <= pwdata[7:0] & BANK_MASK;
      else if (idx == BANK2_IDX) bank2_q <= pwdata[7:0] & BANK_MASK;
      else if (idx == PIN_IDX)   pin_q   <= pwdata[7:0] & PIN_MASK;
      else if (idx == CFG_IDX)   cfg_q   <= pwdata[7:0] & CFG_MASK;
    end
  end

  // registered read data and error
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end
    else if (psel && !penable)
    begin
      prdata  <= {24'h00_0000, rd};
      pslverr <= !mapped;
    end
    // error stands only beside the one-cycle pready
    else
      pslverr <= 1'b0;
  end

endmodule : mwp_apb_regs

// ---- verification/mwp_top_chk.sv ----
// Purpose: port-level checker for the paging unit
// Assumes: sees only the top module ports
// Notes:   paging outputs lag their inputs by one edge
`timescale 1ns/10ps
module mwp_top_chk
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [15:0] cpu_addr,
  input wire logic        cpu_vec_fetch,
  input wire logic        onchip_hit,
  input wire logic        rom_hit,
  input wire logic [5:0]  gpio_dir,
  input wire logic [5:0]  pin_oe_n,
  input wire logic [15:13] bus_addr_hi,
  input wire logic [15:0] vec_addr,
  input wire logic        ext_select,
  input wire logic        rom_select,
  input wire logic [1:0]  win_active
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // apb setup cycle
  sequence s_setup;
    psel && !penable;
  endsequence
  a_ready_after_setup: assert property (s_setup |=> pready) else $error("pready late");
  a_ready_one_cycle: assert property (pready |=> !pready) else $error("pready held");
  a_err_with_ready: assert property (pslverr |-> pready) else $error("pslverr alone");
  a_win_exclusive: assert property (win_active != 2'h3) else $error("both windows");
  a_addr_passthru: assert property ($past(presetn) && win_active == 2'h0
    |-> bus_addr_hi == $past(cpu_addr[15:13])) else $error("high bits not cpu");
  a_vec_expand: assert property (win_active != 2'h0 |-> vec_addr == 16'h7FFE)
    else $error("vector not 7FFE");
  a_onchip_local: assert property ($past(presetn) && $past(onchip_hit)
    |-> !ext_select && !rom_select) else $error("on-chip access left chip");
  a_rom_source: assert property (rom_select
    |-> $past(rom_hit) && !$past(cpu_vec_fetch)) else $error("rom without cause");
  a_ext_on_hit: assert property ($past(presetn) && win_active != 2'h0
    && !$past(onchip_hit) && !$past(rom_hit) |-> ext_select) else $error("hit not ext");
  a_gpio_enable: assert property ($past(presetn)
    |-> (pin_oe_n & $past(gpio_dir)) == 6'h00) else $error("gpio drive lost");
endmodule : mwp_top_chk

bind mwp_top mwp_top_chk u_chk (.pclk, .presetn, .psel, .penable, .pready, .pslverr,
  .cpu_addr, .cpu_vec_fetch, .onchip_hit, .rom_hit, .gpio_dir, .pin_oe_n, .bus_addr_hi,
  .vec_addr, .ext_select, .rom_select, .win_active);

// ---- verification/mwp_ext_mem.sv ----
// Purpose: far-side paged memory, latches the bank lines it sees
// Assumes: lines with enable high are not driven toward it
// Notes:   undriven lines read as pulled up
`timescale 1ns/10ps
module mwp_ext_mem
(
  input wire logic       pclk,
  input wire logic [5:0] pin_out,
  input wire logic [5:0] pin_oe_n,
  input wire logic       ext_select,
  output logic [5:0]     page
);
  // capture the bank on each external access
  always_ff @(posedge pclk)
    if (ext_select)
      page <= pin_out | pin_oe_n;
endmodule : mwp_ext_mem

// ---- verification/test_memory_window_paging.sv ----
// Purpose: self-checking bench for the paging unit
// Assumes: zero-wait apb slave, outputs one edge behind inputs
// Notes:   cfg bit0 marks rom present
`timescale 1ns/10ps
module test_memory_window_paging
  import mwp_pkg::*;
;
  typedef struct packed {
    logic [7:0]  sz, ba, b1, b2, pg;  // register values
    logic [15:0] ad;                  // cpu address
    logic        oh, rh, vf;          // on-chip, rom, vector fetch
    logic [5:0]  po, oe;              // expected pins
    logic [2:0]  bh;                  // expected high bits
    logic [1:0]  wa;                  // expected window
    logic        ex, rs;              // expected selects
    logic [2:0]  m;                   // which groups to check
  } mwp_row_s;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, re;
  logic        cpu_vec_fetch, onchip_hit, rom_hit, ext_select, rom_select;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rq;
  logic [15:0] cpu_addr, vec_addr;
  logic [5:0]  gpio_out, gpio_dir, pin_out, pin_oe_n, page;
  logic [15:13] bus_addr_hi;
  logic [1:0]  win_active;
  int          num_errors = 0;
  int          tests_run = 0;
  mwp_row_s    r;
  logic [7:0]  ix [5] = '{SIZE_IDX, BASE_IDX, BANK1_IDX, BANK2_IDX, PIN_IDX};
  logic [7:0]  wv [5] = '{8'h33, 8'hFF, 8'hFF, 8'hFF, 8'hFF};  // write values
  logic [7:0]  ev [5] = '{8'h33, 8'hEE, 8'h7E, 8'h7E, 8'h3F};  // readback
  mwp_row_s    rows [11] = '{
    '{8'h01,8'h02,8'h56,8'h00,8'h3F,16'h2345,'0,'0,'0,6'h2B,6'h00,3'h3,2'h1,'1,'0,3'h7},
    '{8'h01,8'h02,8'h56,8'h00,8'h07,16'h2345,'0,'0,'0,6'h13,6'h08,3'h3,2'h1,'1,'0,3'h3},
    '{8'h20,8'h80,8'h00,8'h2A,8'h3F,16'hB000,'0,'0,'0,6'h15,6'h00,3'h5,2'h2,'1,'0,3'h7},
    '{8'h21,8'h88,8'h56,8'h2A,8'h3F,16'h8100,'0,'0,'0,6'h2B,6'h00,3'h3,2'h1,'1,'0,3'h3},
    '{8'h21,8'h88,8'h56,8'h2A,8'h3F,16'hA100,'0,'0,'0,6'h15,6'h00,3'h5,2'h2,'1,'0,3'h3},
    '{8'h03,8'h04,8'h10,8'h00,8'h3F,16'h5000,'0,'0,'0,6'h08,6'h00,3'h0,2'h1,'1,'0,3'h7},
    '{8'h01,8'h02,8'h56,8'h00,8'h3F,16'h2345,'1,'0,'0,6'h00,6'h00,3'h0,2'h0,'0,'0,3'h4},
    '{8'h01,8'h02,8'h06,8'h00,8'h3F,16'h2345,'0,'1,'0,6'h00,6'h00,3'h0,2'h0,'0,'1,3'h4},
    '{8'h01,8'h02,8'h16,8'h00,8'h3F,16'h2345,'0,'1,'0,6'h00,6'h00,3'h0,2'h0,'1,'0,3'h4},
    '{8'h01,8'h02,8'h56,8'h00,8'h3F,16'h4000,'0,'0,'0,6'h00,6'h00,3'h2,2'h0,'0,'0,3'h2},
    '{8'h01,8'h02,8'h06,8'h00,8'h3F,16'hFFFE,'0,'1,'1,6'h00,6'h00,3'h0,2'h0,'1,'0,3'h4}};

  mwp_top dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .cpu_addr, .cpu_vec_fetch, .onchip_hit, .rom_hit, .gpio_out,
    .gpio_dir, .pin_out, .pin_oe_n, .bus_addr_hi, .vec_addr, .ext_select, .rom_select,
    .win_active);
  mwp_ext_mem mem (.pclk, .pin_out, .pin_oe_n, .ext_select, .page);

  // free-running bus clock
  always #2 pclk = ~pclk;

  // compare and count
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    tests_run++;
    if (s !== e)
    begin
      num_errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : chk

  // one apb transfer, held until pready
  task automatic xfer(input logic [7:0] idx, input logic wr, input logic [7:0] d);
    psel    <= '1;
    pwrite  <= wr;
    paddr   <= {2'h0, idx, 2'h0};
    pwdata  <= {24'h0, d};
    @(posedge pclk);
    penable <= '1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rq = prdata;
    re = pslverr;
    psel    <= '0;
    penable <= '0;
    @(posedge pclk);
  endtask : xfer

  // verdict and stop
  task automatic end_sim;
    $display("counts: run %0d errors %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : end_sim

  // hang guard
  initial
  begin
    repeat (5000) @(posedge pclk);
    num_errors++;
    end_sim;
  end

  // main sequence
  initial
  begin
    {pclk, presetn, psel, penable, pwrite, cpu_vec_fetch, onchip_hit, rom_hit} = '0;
    {paddr, pwdata, cpu_addr} = '0;
    gpio_out = 6'h15;
    gpio_dir = 6'h30;
    repeat (5) @(posedge pclk);
    chk(32'(pin_oe_n), 32'h3F);
    chk(32'(vec_addr), 32'(VEC_HIGH));
    presetn <= '1;
    @(posedge pclk);
    foreach (ix[i])
    begin
      xfer(ix[i], '0, 8'h00);
      chk(rq, 32'h0);
      xfer(ix[i], '1, wv[i]);
      xfer(ix[i], '0, 8'h00);
      chk(rq, 32'(ev[i]));
    end
    xfer(8'hC0, '1, 8'hFF);
    xfer(8'hC0, '0, 8'h00);
    chk(rq, 32'h0);
    chk(32'(re), 32'h1);
    $display("register test done");
    xfer(CFG_IDX, '1, 8'h03);
    xfer(SIZE_IDX, '1, 8'h00);
    cpu_addr <= 16'hA000;
    repeat (2) @(posedge pclk);
    chk(32'(vec_addr), 32'(VEC_HIGH));
    chk(32'(pin_out), 32'h15);
    chk(32'(pin_oe_n), 32'h08);
    chk(32'(bus_addr_hi), 32'h5);
    $display("idle window test done");
    xfer(CFG_IDX, '1, 8'h01);
    foreach (rows[i])
    begin
      r = rows[i];
      xfer(SIZE_IDX, '1, r.sz);
      xfer(BASE_IDX, '1, r.ba);
      xfer(BANK1_IDX, '1, r.b1);
      xfer(BANK2_IDX, '1, r.b2);
      xfer(PIN_IDX, '1, r.pg);
      cpu_addr      <= r.ad;
      onchip_hit    <= r.oh;
      rom_hit       <= r.rh;
      cpu_vec_fetch <= r.vf;
      repeat (3) @(posedge pclk);
      if (r.m[0]) chk(32'(pin_out), 32'(r.po));
      if (r.m[0]) chk(32'(pin_oe_n), 32'(r.oe));
      if (r.m[0] && r.ex) chk(32'(page), 32'(r.po | r.oe));
      if (r.m[1]) chk(32'(win_active), 32'(r.wa));
      if (r.m[1]) chk(32'(bus_addr_hi), 32'(r.bh));
      if (r.m[2]) chk(32'(ext_select), 32'(r.ex));
      if (r.m[2]) chk(32'(rom_select), 32'(r.rs));
      chk(32'(vec_addr), 32'(VEC_EXP));
      $display("row %0d done", i);
    end
    // mid-run reset returns every register to zero
    presetn <= '0;
    repeat (5) @(posedge pclk);
    chk(32'(win_active), 32'h0);
    chk(32'(vec_addr), 32'(VEC_HIGH));
    presetn <= '1;
    @(posedge pclk);
    foreach (ix[i])
    begin
      xfer(ix[i], '0, 8'h00);
      chk(rq, 32'h0);
    end
    $display("reset test done");
    end_sim;
  end
endmodule : test_memory_window_paging
